// File: ead_consts.vh
// constants shared by the effective-address field decoder
`ifndef EAD_CONSTS_VH
`define EAD_CONSTS_VH

// instruction formats
`define EAD_FMT_NONE 3'h0
`define EAD_FMT_ONE 3'h1
`define EAD_FMT_TWO 3'h2
`define EAD_FMT_ACC 3'h3
`define EAD_FMT_RR 3'h4

// decoded addressing modes
`define EAD_MODE_REG 3'h0
`define EAD_MODE_IND 3'h1
`define EAD_MODE_INC 3'h2
`define EAD_MODE_DEC 3'h3
`define EAD_MODE_IMM 3'h4
`define EAD_MODE_ABS 3'h5
`define EAD_MODE_SCL 3'h6
`define EAD_MODE_IDX 3'h7

// register bank selection
`define EAD_BANK_GLOBAL 2'h0
`define EAD_BANK_CURRENT 2'h1
`define EAD_BANK_PREVIOUS 2'h2

// specifier byte fields
`define EAD_SPEC_ACC_BIT 7
`define EAD_SPEC_CODE_HI 6
`define EAD_SIZE_HI 5
`define EAD_SIZE_LO 4
`define EAD_REG_HI 3
`define EAD_REG_LO 0
`define EAD_EXT_MBZ_BIT 7
`define EAD_EXT_LONG_BIT 6
`define EAD_CSIZE_HI 1
`define EAD_CSIZE_LO 0

// size field values
`define EAD_SIZE_NONE 2'h0
`define EAD_SIZE_1 2'h1
`define EAD_SIZE_2 2'h2
`define EAD_SIZE_4 2'h3

// register offsets (word index on the 2-bit address)
`define EAD_REG_STATUS 2'h0
`define EAD_REG_MASK 2'h1
`define EAD_REG_CTRL 2'h2
`define EAD_REG_STATE 2'h3

// status and mask bit positions
`define EAD_EV_ILLEGAL 0
`define EAD_EV_BANK 1
`define EAD_EV_DONE 2
`define EAD_EV_W 3

// control bit positions and reset values
`define EAD_CTRL_RING_BIT 0
`define EAD_CTRL_NODIR_BIT 1
`define EAD_STATUS_RST 3'h0
`define EAD_MASK_RST 3'h0
`define EAD_CTRL_RST 2'h0

`endif

// File: ead_fetch_model.sv
// behavioural instruction fetch stage that feeds bytes to the decoder
module ead_fetch_model (
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_busy,
   input wire logic i_slow,
   output logic o_valid,
   output logic [7:0] o_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic gap = 1'b0;
   logic taken;
   logic hold;
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   task automatic flush();
      q.delete();
   endtask
   initial begin
      o_valid = 1'b0;
      o_byte = 8'h5A;
   end
   // a byte on offer is held until taken; idle line toggles so no stale value is seen
   always @(posedge i_clk) begin
      taken = o_valid && i_busy && i_ce;
      hold = o_valid && !taken;
      if (taken && q.size() > 0) begin
         void'(q.pop_front());
      end
      gap <= i_slow && !gap;
      if (q.size() > 0 && (hold || !(i_slow && gap))) begin
         o_valid <= 1'b1;
         o_byte <= q[0];
      end else begin
         o_valid <= 1'b0;
         o_byte <= ~o_byte;
      end
   end
endmodule // ead_fetch_model

// File: ead_field_decoder.v
// effective-address field decoder with its register port and interrupt
//
// Contract
// - accept no-operand, one-operand, two-operand, accumulator and register-register formats.
// - each specifier may be followed by expansion bytes set by its mode and size field.
// - specifier is accumulator bit plus seven-bit mode or register code.
// - two-operand: A one means destination R0; A zero fetches a destination specifier.
// - one-operand instructions ignore the accumulator bit entirely.
// - A one with a destination barred from register direct raises illegal instruction.
// - code 100 is register direct, low nibble register, no expansion.
// - leading zero is register indirect; size 00/01/10/11 gives 0/1/2/4 bytes.
// - code 101 is post-increment register indirect, no expansion.
// - code 110 is pre-decrement register indirect, no expansion.
// - code 11100 is immediate of 1/2/4 bytes; size 00 is current-bank prefix.
// - code 11101 is absolute address of 1/2/4 bytes.
// - code 11101 with size 00 is the previous-bank prefix.
// - code 11110 is scaled indirect; extra byte holds scale x1/x2/x4/x8.
// - code 1111100 is indexed; expansion holds width, size, scale, index register.
// - index width bit zero selects word index, one selects long index.
// - bank prefixes outside ring mode raise a bank-mode exception.
module ead_field_decoder (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_start,
   input wire [2:0] i_format,
   input wire i_byte_valid,
   input wire [7:0] i_byte,
   input wire [1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire o_busy,
   output wire o_byte_ready,
   output reg o_op_valid,
   output reg o_op_dest,
   output reg [2:0] o_mode,
   output reg [1:0] o_bank,
   output reg [3:0] o_base_register,
   output reg [1:0] o_displacement_size,
   output reg [2:0] o_exp_bytes,
   output reg [1:0] o_scale_factor,
   output reg [3:0] o_index_register,
   output reg o_index_long,
   output reg o_dest_acc,
   output reg o_done,
   output reg o_illegal,
   output reg o_bank_exc,
   output reg [7:0] o_rdata,
   output wire o_irq
);

`include "ead_consts.vh"

   // ************************************************************
   // state machine
   // ************************************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SPEC = 3'h1;
   localparam [2:0] ST_EXT1 = 3'h2;
   localparam [2:0] ST_EXT2 = 3'h3;
   localparam [2:0] ST_EXPN = 3'h4;

   // byte count of a size field, used for every sized mode
   function [2:0] size_bytes;
      input [1:0] sz;
      begin
         case (sz)
            `EAD_SIZE_NONE: size_bytes = 3'h0;
            `EAD_SIZE_1: size_bytes = 3'h1;
            `EAD_SIZE_2: size_bytes = 3'h2;
            `EAD_SIZE_4: size_bytes = 3'h4;
            default: size_bytes = 3'h0;
         endcase
      end
   endfunction

   reg [2:0] state_r, state_nxt;
   reg [2:0] fmt_r, fmt_nxt;
   reg opnd_r, opnd_nxt;
   reg acc_r, acc_nxt;
   reg [2:0] mode_r, mode_nxt;
   reg [1:0] bank_r, bank_nxt;
   reg [3:0] base_r, base_nxt;
   reg [1:0] size_r, size_nxt;
   reg [1:0] sf_r, sf_nxt;
   reg [3:0] xm_r, xm_nxt;
   reg xl_r, xl_nxt;
   reg [2:0] cnt_r, cnt_nxt;
   reg [2:0] exp_r, exp_nxt;
   reg [2:0] status_r, status_nxt;
   reg [2:0] mask_r;
   reg [1:0] ctrl_r;

   reg op_valid_nxt, done_nxt, illegal_nxt, bank_exc_nxt, dest_acc_nxt;
   reg complete;
   reg take;
   reg [6:0] code;

   wire ring_mode = ctrl_r[`EAD_CTRL_RING_BIT];
   wire dst_no_regdir = ctrl_r[`EAD_CTRL_NODIR_BIT];

   assign o_busy = (state_r != ST_IDLE);
   assign o_byte_ready = o_busy;
   assign o_irq = |(status_r & mask_r);

   // ************************************************************
   // decode
   // ************************************************************
   always @* begin
      state_nxt = state_r;
      fmt_nxt = fmt_r;
      opnd_nxt = opnd_r;
      acc_nxt = acc_r;
      mode_nxt = mode_r;
      bank_nxt = bank_r;
      base_nxt = base_r;
      size_nxt = size_r;
      sf_nxt = sf_r;
      xm_nxt = xm_r;
      xl_nxt = xl_r;
      cnt_nxt = cnt_r;
      exp_nxt = exp_r;
      op_valid_nxt = 1'b0;
      done_nxt = 1'b0;
      illegal_nxt = 1'b0;
      bank_exc_nxt = 1'b0;
      dest_acc_nxt = o_dest_acc;
      complete = 1'b0;
      take = i_byte_valid && (state_r != ST_IDLE);
      code = i_byte[`EAD_SPEC_CODE_HI:0];
      case (state_r)
         ST_IDLE: begin
            if (i_start) begin
               fmt_nxt = i_format;
               opnd_nxt = 1'b0;
               acc_nxt = 1'b0;
               bank_nxt = `EAD_BANK_GLOBAL;
               dest_acc_nxt = 1'b0;
               case (i_format)
                  `EAD_FMT_ONE, `EAD_FMT_TWO: state_nxt = ST_SPEC;
                  `EAD_FMT_NONE, `EAD_FMT_ACC, `EAD_FMT_RR: done_nxt = 1'b1;
                  default: illegal_nxt = 1'b1;
               endcase
            end
         end
         ST_SPEC: begin
            if (take) begin
               // a prefix byte also carries the accumulator bit; the last one wins
               if ((fmt_r == `EAD_FMT_TWO) && !opnd_r) begin
                  acc_nxt = i_byte[`EAD_SPEC_ACC_BIT];
               end
               base_nxt = i_byte[`EAD_REG_HI:`EAD_REG_LO];
               size_nxt = i_byte[`EAD_SIZE_HI:`EAD_SIZE_LO];
               sf_nxt = 2'h0;
               xm_nxt = 4'h0;
               xl_nxt = 1'b0;
               casez (code)
                  7'b0??????: begin
                     mode_nxt = `EAD_MODE_IND;
                     exp_nxt = size_bytes(i_byte[`EAD_SIZE_HI:`EAD_SIZE_LO]);
                     complete = 1'b1;
                  end
                  7'b100????: begin
                     mode_nxt = `EAD_MODE_REG;
                     size_nxt = `EAD_SIZE_NONE;
                     exp_nxt = 3'h0;
                     complete = 1'b1;
                  end
                  7'b101????: begin
                     mode_nxt = `EAD_MODE_INC;
                     size_nxt = `EAD_SIZE_NONE;
                     exp_nxt = 3'h0;
                     complete = 1'b1;
                  end
                  7'b110????: begin
                     mode_nxt = `EAD_MODE_DEC;
                     size_nxt = `EAD_SIZE_NONE;
                     exp_nxt = 3'h0;
                     complete = 1'b1;
                  end
                  7'b11100??, 7'b11101??: begin
                     // these codes carry their size in the low two code bits
                     if (i_byte[`EAD_CSIZE_HI:`EAD_CSIZE_LO] == `EAD_SIZE_NONE) begin
                        bank_nxt = code[2] ? `EAD_BANK_PREVIOUS : `EAD_BANK_CURRENT;
                        if (!ring_mode) begin
                           bank_exc_nxt = 1'b1;
                           state_nxt = ST_IDLE;
                        end
                     end else begin
                        mode_nxt = code[2] ? `EAD_MODE_ABS : `EAD_MODE_IMM;
                        base_nxt = 4'h0;
                        size_nxt = i_byte[`EAD_CSIZE_HI:`EAD_CSIZE_LO];
                        exp_nxt = size_bytes(i_byte[`EAD_CSIZE_HI:`EAD_CSIZE_LO]);
                        complete = 1'b1;
                     end
                  end
                  7'b11110??: begin
                     mode_nxt = `EAD_MODE_SCL;
                     size_nxt = i_byte[`EAD_CSIZE_HI:`EAD_CSIZE_LO];
                     state_nxt = ST_EXT1;
                  end
                  7'b1111100: begin
                     mode_nxt = `EAD_MODE_IDX;
                     state_nxt = ST_EXT1;
                  end
                  default: begin
                     // relative and double-indirect forms are not handled here
                     illegal_nxt = 1'b1;
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_EXT1: begin
            if (take) begin
               if (mode_r == `EAD_MODE_SCL) begin
                  sf_nxt = i_byte[`EAD_SIZE_HI:`EAD_SIZE_LO];
                  base_nxt = i_byte[`EAD_REG_HI:`EAD_REG_LO];
                  exp_nxt = size_bytes(size_r);
                  complete = 1'b1;
               end else if (i_byte[`EAD_EXT_MBZ_BIT]) begin
                  illegal_nxt = 1'b1;
                  state_nxt = ST_IDLE;
               end else begin
                  xl_nxt = i_byte[`EAD_EXT_LONG_BIT];
                  size_nxt = i_byte[`EAD_SIZE_HI:`EAD_SIZE_LO];
                  base_nxt = i_byte[`EAD_REG_HI:`EAD_REG_LO];
                  state_nxt = ST_EXT2;
               end
            end
         end
         ST_EXT2: begin
            if (take) begin
               sf_nxt = i_byte[`EAD_SIZE_HI:`EAD_SIZE_LO];
               xm_nxt = i_byte[`EAD_REG_HI:`EAD_REG_LO];
               exp_nxt = size_bytes(size_r);
               complete = 1'b1;
            end
         end
         ST_EXPN: begin
            if (take) begin
               cnt_nxt = cnt_r - 3'h1;
               if (cnt_r == 3'h1) begin
                  state_nxt = ST_SPEC;
                  cnt_nxt = 3'h0;
                  complete = 1'b1;
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase

      // an operand is reported only once its expansion bytes are all in
      if (complete) begin
         if ((state_r != ST_EXPN) && (exp_nxt != 3'h0)) begin
            cnt_nxt = exp_nxt;
            state_nxt = ST_EXPN;
         end else begin
            op_valid_nxt = 1'b1;
            if ((fmt_r == `EAD_FMT_TWO) && !opnd_r) begin
               if (acc_nxt) begin
                  dest_acc_nxt = 1'b1;
                  if (dst_no_regdir) begin
                     illegal_nxt = 1'b1;
                  end else begin
                     done_nxt = 1'b1;
                  end
                  state_nxt = ST_IDLE;
               end else begin
                  // destination decoding starts only here, after the source stream
                  opnd_nxt = 1'b1;
                  bank_nxt = `EAD_BANK_GLOBAL;
                  state_nxt = ST_SPEC;
               end
            end else begin
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
      end
   end

   // ************************************************************
   // register port and sticky events
   // ************************************************************
   always @* begin
      status_nxt = status_r;
      if (i_wr && (i_addr == `EAD_REG_STATUS)) begin
         status_nxt = status_r & ~i_wdata[`EAD_EV_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      status_nxt[`EAD_EV_ILLEGAL] = status_nxt[`EAD_EV_ILLEGAL] | illegal_nxt;
      status_nxt[`EAD_EV_BANK] = status_nxt[`EAD_EV_BANK] | bank_exc_nxt;
      status_nxt[`EAD_EV_DONE] = status_nxt[`EAD_EV_DONE] | done_nxt;
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         fmt_r <= `EAD_FMT_NONE;
         opnd_r <= 1'b0;
         acc_r <= 1'b0;
         mode_r <= `EAD_MODE_REG;
         bank_r <= `EAD_BANK_GLOBAL;
         base_r <= 4'h0;
         size_r <= `EAD_SIZE_NONE;
         sf_r <= 2'h0;
         xm_r <= 4'h0;
         xl_r <= 1'b0;
         cnt_r <= 3'h0;
         exp_r <= 3'h0;
         status_r <= `EAD_STATUS_RST;
         mask_r <= `EAD_MASK_RST;
         ctrl_r <= `EAD_CTRL_RST;
         o_op_valid <= 1'b0;
         o_op_dest <= 1'b0;
         o_mode <= `EAD_MODE_REG;
         o_bank <= `EAD_BANK_GLOBAL;
         o_base_register <= 4'h0;
         o_displacement_size <= `EAD_SIZE_NONE;
         o_exp_bytes <= 3'h0;
         o_scale_factor <= 2'h0;
         o_index_register <= 4'h0;
         o_index_long <= 1'b0;
         o_dest_acc <= 1'b0;
         o_done <= 1'b0;
         o_illegal <= 1'b0;
         o_bank_exc <= 1'b0;
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         state_r <= state_nxt;
         fmt_r <= fmt_nxt;
         opnd_r <= opnd_nxt;
         acc_r <= acc_nxt;
         mode_r <= mode_nxt;
         bank_r <= bank_nxt;
         base_r <= base_nxt;
         size_r <= size_nxt;
         sf_r <= sf_nxt;
         xm_r <= xm_nxt;
         xl_r <= xl_nxt;
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
         status_r <= status_nxt;
         o_op_valid <= op_valid_nxt;
         o_done <= done_nxt;
         o_illegal <= illegal_nxt;
         o_bank_exc <= bank_exc_nxt;
         o_dest_acc <= dest_acc_nxt;
         if (op_valid_nxt) begin
            o_op_dest <= opnd_r;
            o_mode <= mode_nxt;
            o_bank <= bank_nxt;
            o_base_register <= base_nxt;
            o_displacement_size <= size_nxt;
            o_exp_bytes <= exp_nxt;
            o_scale_factor <= sf_nxt;
            o_index_register <= xm_nxt;
            o_index_long <= xl_nxt;
         end
         if (i_wr && (i_addr == `EAD_REG_MASK)) begin
            mask_r <= i_wdata[`EAD_EV_W-1:0];
         end
         if (i_wr && (i_addr == `EAD_REG_CTRL)) begin
            ctrl_r <= i_wdata[1:0];
         end
         if (i_rd) begin
            case (i_addr)
               `EAD_REG_STATUS: o_rdata <= {5'h00, status_r};
               `EAD_REG_MASK: o_rdata <= {5'h00, mask_r};
               `EAD_REG_CTRL: o_rdata <= {6'h00, ctrl_r};
               `EAD_REG_STATE: o_rdata <= {1'b0, cnt_r, opnd_r, state_r};
               default: o_rdata <= 8'h00;
            endcase
         end else begin
            // read data stand only in the cycle after the strobe
            o_rdata <= 8'h00;
         end
      end
   end

endmodule // ead_field_decoder

// File: ead_field_decoder_asserts.sv
// port-level assertion checker for the effective-address field decoder
`include "ead_consts.vh"
module ead_field_decoder_asserts (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_start,
   input wire [2:0] i_format,
   input wire i_byte_valid,
   input wire [7:0] i_byte,
   input wire o_busy,
   input wire o_byte_ready,
   input wire o_op_valid,
   input wire o_op_dest,
   input wire [2:0] o_mode,
   input wire [3:0] o_base_register,
   input wire [1:0] o_displacement_size,
   input wire [2:0] o_exp_bytes,
   input wire [1:0] o_scale_factor,
   input wire o_done,
   input wire o_illegal,
   input wire o_bank_exc
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   function automatic logic [2:0] nb(input logic [1:0] s);
      return (s == 2'h3) ? 3'h4 : {1'b0, s};
   endfunction
   // ****************************************
   // sequences
   // ****************************************
   sequence s_go;
      i_ce && !o_busy && i_start;
   endsequence
   sequence s_src_ind1;
      o_busy && i_byte_valid && i_byte == 8'h15 ##1 o_busy && i_byte_valid;
   endsequence
   // ****************************************
   // properties
   // ****************************************
   ready_tracks_busy_a: assert property (o_byte_ready == o_busy)
      else $error("byte ready differs from busy");
   simple_done_a: assert property (s_go ##0 (i_format inside {3'h0, 3'h3, 3'h4})
      |=> o_done && !o_illegal) else $error("short format not done next cycle");
   bad_format_a: assert property (s_go ##0 (i_format > 3'h4)
      |=> o_illegal && !o_done) else $error("bad format not refused");
   reg_direct_a: assert property (o_op_valid && o_mode == `EAD_MODE_REG
      |-> o_exp_bytes == 3'h0 && o_displacement_size == 2'h0) else $error("reg direct size");
   indirect_size_a: assert property (o_op_valid && o_mode == `EAD_MODE_IND
      |-> o_exp_bytes == nb(o_displacement_size)) else $error("indirect byte count");
   auto_step_a: assert property (o_op_valid && o_mode inside {`EAD_MODE_INC, `EAD_MODE_DEC}
      |-> o_exp_bytes == 3'h0) else $error("auto step has expansion");
   imm_abs_a: assert property (o_op_valid && o_mode inside {`EAD_MODE_IMM, `EAD_MODE_ABS}
      |-> o_displacement_size != 2'h0 && o_exp_bytes == nb(o_displacement_size)
      && o_base_register == 4'h0) else $error("immediate or absolute count");
   scale_clear_a: assert property (o_op_valid && !(o_mode inside {`EAD_MODE_SCL, `EAD_MODE_IDX})
      |-> o_scale_factor == 2'h0) else $error("scale set outside scaled modes");
   end_idle_a: assert property (o_done || o_illegal || o_bank_exc |-> !o_busy)
      else $error("busy after end of instruction");
   src_first_a: assert property (s_go ##0 i_format == `EAD_FMT_TWO ##1 s_src_ind1
      |=> o_op_valid && !o_op_dest && o_mode == `EAD_MODE_IND && o_exp_bytes == 3'h1)
      else $error("source operand not finished first");
endmodule // ead_field_decoder_asserts

// File: ead_field_decoder_tb_top.sv
// self-checking bench for the effective-address field decoder
`include "ead_consts.vh"
module ead_field_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_start = 1'b0;
   logic [2:0] i_format = 3'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic slow = 1'b0;
   wire bv, busy, rdy, opv, opd, dacc, done, ill, bexc, lng, irq;
   wire [7:0] bt, rdata;
   wire [2:0] mode, nexp;
   wire [1:0] bank, dsz, sf;
   wire [3:0] base, xr;
   logic [2:0] ev = 3'h0;
   logic [21:0] ops[$];
   logic [7:0] none[$];
   logic [7:0] q[$];
   int n_mismatch = 0;
   int checks = 0;
   always #2.5 i_clk = ~i_clk;
   ead_field_decoder ead_field_decoder_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_start(i_start), .i_format(i_format), .i_byte_valid(bv), .i_byte(bt), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_busy(busy), .o_byte_ready(rdy),
      .o_op_valid(opv), .o_op_dest(opd), .o_mode(mode), .o_bank(bank), .o_base_register(base),
      .o_displacement_size(dsz), .o_exp_bytes(nexp), .o_scale_factor(sf), .o_index_register(xr),
      .o_index_long(lng), .o_dest_acc(dacc), .o_done(done), .o_illegal(ill), .o_bank_exc(bexc),
      .o_rdata(rdata), .o_irq(irq));
   ead_fetch_model ead_fetch_model_inst (.i_clk(i_clk), .i_ce(i_ce), .i_busy(rdy), .i_slow(slow),
      .o_valid(bv), .o_byte(bt));
   always @(posedge i_clk) begin
      if (opv === 1'b1) ops.push_back({opd, mode, bank, base, dsz, nexp, sf, xr, lng});
      ev = ev | {bexc, ill, done};
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      cmp(rdata, e);
   endtask
   function automatic logic [21:0] rec(input logic [2:0] m, input logic [1:0] bk,
      input logic [3:0] b, input logic [1:0] ds, input logic [1:0] s, input logic [3:0] x,
      input logic l, input logic d = 1'b0);
      return {d, m, bk, b, ds, (ds == 2'h3) ? 3'h4 : {1'b0, ds}, s, x, l};
   endfunction
   task automatic run(input logic [2:0] f, input logic [7:0] bs[$]);
      foreach (bs[k]) ead_fetch_model_inst.push(bs[k]);
      @(posedge i_clk);
      i_start <= 1'b1;
      i_format <= f;
      @(posedge i_clk);
      i_start <= 1'b0;
      #1;
      ev = 3'h0;
      ops.delete();
      repeat (60) begin
         @(posedge i_clk);
         #1;
         if (ev != 3'h0) break;
      end
      ead_fetch_model_inst.flush();
   endtask
   task automatic op(input logic [2:0] f, input logic [7:0] bs[$], input logic [2:0] eev,
      input logic [21:0] er);
      run(f, bs);
      cmp(ev, eev);
      if (eev == 3'h1 && bs.size() > 0) cmp(ops[$], er);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
      wr(2'h1, 8'h05);
      rd(2'h1, 8'h05);
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h00);
      wr(2'h1, 8'h00);
   endtask
   task automatic t_formats;
      for (int f = 0; f < 8; f++)
         if (f != 1 && f != 2) op(3'(f), none, (f < 5) ? 3'h1 : 3'h2, 22'h0);
   endtask
   task automatic t_modes;
      slow = 1'b1;
      op(3'h1, {8'h43}, 3'h1, rec(`EAD_MODE_REG, 0, 3, 0, 0, 0, 0));
      wr(2'h2, 8'h02);
      op(3'h1, {8'hC3}, 3'h1, rec(`EAD_MODE_REG, 0, 3, 0, 0, 0, 0));
      wr(2'h2, 8'h00);
      for (int s = 0; s < 4; s++) begin
         q = {8'h05 | 8'(s << 4)};
         repeat ((s == 3) ? 4 : s) q.push_back(8'hA5);
         op(3'h1, q, 3'h1, rec(`EAD_MODE_IND, 0, 5, 2'(s), 0, 0, 0));
      end
      op(3'h1, {8'h5A}, 3'h1, rec(`EAD_MODE_INC, 0, 4'hA, 0, 0, 0, 0));
      op(3'h1, {8'h6C}, 3'h1, rec(`EAD_MODE_DEC, 0, 4'hC, 0, 0, 0, 0));
      for (int m = 0; m < 2; m++)
         for (int s = 1; s < 4; s++) begin
            q = {8'h70 | 8'(m << 2) | 8'(s)};
            repeat ((s == 3) ? 4 : s) q.push_back(8'h3C);
            op(3'h1, q, 3'h1, rec(3'(`EAD_MODE_IMM + m), 0, 0, 2'(s), 0, 0, 0));
         end
      op(3'h1, {8'h79, 8'h36, 8'hEE}, 3'h1, rec(`EAD_MODE_SCL, 0, 6, 1, 3, 0, 0));
      op(3'h1, {8'h7C, 8'h69, 8'h2B, 8'h11, 8'h22}, 3'h1,
         rec(`EAD_MODE_IDX, 0, 9, 2, 2, 4'hB, 1));
      op(3'h1, {8'h7C, 8'h09, 8'h1B}, 3'h1, rec(`EAD_MODE_IDX, 0, 9, 0, 1, 4'hB, 0));
      op(3'h1, {8'h7C, 8'h89}, 3'h2, 22'h0);
      for (int c = 8'h7D; c < 8'h80; c++) op(3'h1, {8'(c)}, 3'h2, 22'h0);
      slow = 1'b0;
   endtask
   task automatic t_prefix;
      op(3'h1, {8'h70, 8'h43}, 3'h4, 22'h0);
      op(3'h1, {8'h74, 8'h43}, 3'h4, 22'h0);
      wr(2'h2, 8'h01);
      op(3'h1, {8'h70, 8'h43}, 3'h1, rec(`EAD_MODE_REG, 1, 3, 0, 0, 0, 0));
      op(3'h1, {8'h74, 8'h43}, 3'h1, rec(`EAD_MODE_REG, 2, 3, 0, 0, 0, 0));
      op(3'h1, {8'h70, 8'h74, 8'h43}, 3'h1, rec(`EAD_MODE_REG, 2, 3, 0, 0, 0, 0));
      wr(2'h2, 8'h00);
   endtask
   task automatic t_two_op;
      run(3'h2, {8'h15, 8'hAA, 8'h43});
      cmp(ev, 3'h1);
      cmp(ops.size(), 2);
      cmp(ops[0], rec(`EAD_MODE_IND, 0, 5, 1, 0, 0, 0));
      cmp(ops[$], rec(`EAD_MODE_REG, 0, 3, 0, 0, 0, 0, 1));
      cmp(dacc, 1'b0);
      op(3'h2, {8'hC3}, 3'h1, rec(`EAD_MODE_REG, 0, 3, 0, 0, 0, 0));
      cmp(dacc, 1'b1);
      wr(2'h2, 8'h02);
      op(3'h2, {8'hC3}, 3'h2, 22'h0);
      wr(2'h2, 8'h00);
   endtask
   task automatic t_irq;
      wr(2'h0, 8'h07);
      wr(2'h1, 8'h07);
      op(3'h5, none, 3'h2, 22'h0);
      rd(2'h0, 8'h01);
      cmp(irq, 1'b1);
      wr(2'h0, 8'h01);
      #1;
      cmp(irq, 1'b0);
      op(3'h1, {8'h70, 8'h43}, 3'h4, 22'h0);
      rd(2'h0, 8'h02);
      wr(2'h1, 8'h00);
      #1;
      cmp(irq, 1'b0);
      wr(2'h0, 8'h02);
      op(3'h0, none, 3'h1, 22'h0);
      rd(2'h0, 8'h04);
   endtask
   task automatic t_ce;
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(2'h1, 8'h07);
      @(posedge i_clk);
      i_ce <= 1'b1;
      rd(2'h1, 8'h00);
   endtask
   task automatic give_verdict;
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_regs;
      t_ce;
      t_formats;
      t_modes;
      t_prefix;
      t_two_op;
      t_irq;
      give_verdict;
   end
   // the whole run needs a few hundred cycles; this cuts a hang short
   initial begin
      #100000;
      n_mismatch++;
      give_verdict;
   end
endmodule // ead_field_decoder_tb_top

bind ead_field_decoder ead_field_decoder_asserts ead_field_decoder_asserts_inst (.i_clk, .i_rst_n,
   .i_ce, .i_start, .i_format, .i_byte_valid, .i_byte, .o_busy, .o_byte_ready, .o_op_valid,
   .o_op_dest, .o_mode, .o_base_register, .o_displacement_size, .o_exp_bytes, .o_scale_factor,
   .o_done, .o_illegal, .o_bank_exc);
